// file: hdl/clock_network_pkg.sv
// Constants shared by the clock network selection and gating logic
package clock_network_pkg;

  // ---------------------------------------------------------------
  // Network counts
  // ---------------------------------------------------------------
  localparam int NUM_GLOBAL = 16;
  localparam int NUM_REGIONAL = 32;
  localparam int NUM_QUAD = 4;
  localparam int REG_PER_QUAD = 8;
  localparam int NUM_EXT = 4;
  localparam int NUM_PIN = 16;
  localparam int NUM_PLL = 12;
  localparam int QUAD_RES = 24;
  localparam int ROW_PER_QUAD = 6;
  localparam int CLUSTER_PICK = 3;
  localparam int IO_PER_QUAD = 8;
  localparam int NUM_SRC = 5;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int SEL_W = 3;
  localparam int RES_SEL_W = 5;
  localparam int ROW_SEL_W = 3;
  localparam int CELL_CFG_W = 7;
  localparam int CLUS_CFG_W = 9;

  // ---------------------------------------------------------------
  // Source inputs of every control cell
  // ---------------------------------------------------------------
  localparam logic [2:0] SRC_PIN_EVEN = 3'h0;
  localparam logic [2:0] SRC_PIN_ODD = 3'h1;
  localparam logic [2:0] SRC_PLL_C0 = 3'h2;
  localparam logic [2:0] SRC_PLL_C1 = 3'h3;
  localparam logic [2:0] SRC_INTERNAL = 3'h4;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 10'h000;
  localparam logic [ADDR_W-1:0] ADDR_STAT_GLOBAL = 10'h004;
  localparam logic [ADDR_W-1:0] ADDR_STAT_REGIONAL = 10'h008;
  localparam logic [ADDR_W-1:0] ADDR_STAT_EXT = 10'h00C;
  localparam logic [ADDR_W-1:0] ADDR_EXT_BASE = 10'h010;
  localparam logic [ADDR_W-1:0] ADDR_GLOBAL_BASE = 10'h040;
  localparam logic [ADDR_W-1:0] ADDR_REGIONAL_BASE = 10'h080;
  localparam logic [ADDR_W-1:0] ADDR_ROW_BASE = 10'h100;
  localparam logic [ADDR_W-1:0] ADDR_IO_BASE = 10'h200;
  localparam logic [ADDR_W-1:0] ADDR_CLUSTER_BASE = 10'h300;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_USER_MODE_BIT = 0;
  localparam int CELL_SEL_LSB = 0;
  localparam int CELL_DYN_BIT = 3;
  localparam int CELL_PD_BIT = 4;
  localparam int CELL_DUAL_BIT = 5;
  localparam int CELL_IOSEL_BIT = 5;
  localparam int CELL_CORNER_BIT = 6;
  localparam logic [CELL_CFG_W-1:0] CELL_CFG_RESET = 7'h10;
  localparam logic [RES_SEL_W-1:0] RES_SEL_RESET = 5'h00;
  localparam logic [CLUS_CFG_W-1:0] CLUS_CFG_RESET = 9'h088;
  localparam logic [NUM_PLL-1:0] CORNER_PLL_MASK = 12'h780;

endpackage

// file: hdl/clock_control_cell.sv
// One clock control cell: source selection and synchronous power-down
`timescale 1ns/1ps
`default_nettype none

module clock_control_cell
  import clock_network_pkg::*;
#(
  parameter bit DYNAMIC = 1'b1
)
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [NUM_SRC-1:0] src,
  input wire logic [SEL_W-1:0] static_sel,
  input wire logic dyn_mode,
  input wire logic [1:0] dyn_sel,
  input wire logic pll_dyn_ok,
  input wire logic power_down,
  input wire logic net_en,
  output logic net_q,
  output logic en_q
);

  // ---------------------------------------------------------------
  // Source selection
  // ---------------------------------------------------------------
  // Run-time choice covers pins and PLL counters only, never internal
  // logic, and falls back to the static choice for a corner PLL.
  logic use_dyn;
  logic [SEL_W-1:0] sel;
  logic chosen;
  logic en_d;
  logic net_d;

  assign use_dyn = DYNAMIC && dyn_mode &&
                   (!dyn_sel[1] || pll_dyn_ok);
  assign sel = use_dyn ? {1'b0, dyn_sel} : static_sel;
  assign chosen = (sel <= SRC_INTERNAL) ? src[sel] : 1'b0;

  // ---------------------------------------------------------------
  // Gating
  // ---------------------------------------------------------------
  // Enable only moves while the source is low, so a high phase is never
  // cut short. A source stuck high therefore freezes the enable.
  assign en_d = chosen ? en_q : (net_en && !power_down);
  assign net_d = chosen && en_q;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      en_q <= 1'b0;
      net_q <= 1'b0;
    end
    else
    begin
      en_q <= en_d;
      net_q <= net_d;
    end
  end

endmodule

`default_nettype wire

// file: hdl/clock_network_select_gate.sv
// Clock network control: cells, quadrant buses and configuration port
//
// What this block does
// - Each global, regional, external output owns a cell
// - Sixteen global and thirty-two regional networks
// - Global source from static bits or run-time logic
// - Run-time choice only positive pins or PLL counters
// - Corner PLLs never run-time selectable in globals
// - Regional and external sources static, fixed in user mode
// - User logic enables networks synchronously, PLL independent
// - Powered-down network shows no clock activity
// - Static power-down bits; unused networks default off
// - External pin muxes user signal or cell output
// - Quadrant has 24 resources feeding row buses
// - Cluster picks three of six row clocks
// - I/O region takes eight of 24 quadrant clocks
// - One source may drive two adjacent regional lines
// - Dual direction by side; corner PLLs never dual
`timescale 1ns/1ps
`default_nettype none

module clock_network_select_gate
  import clock_network_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [NUM_PIN-1:0] positive_clock_pin,
  input wire logic [NUM_PLL-1:0] pll_counter_output_zero,
  input wire logic [NUM_PLL-1:0] pll_counter_output_one,
  input wire logic [NUM_GLOBAL-1:0] global_internal_src,
  input wire logic [NUM_REGIONAL-1:0] regional_internal_src,
  input wire logic [NUM_EXT-1:0] ext_internal_src,
  input wire logic [2*NUM_GLOBAL-1:0] global_dyn_sel,
  input wire logic [NUM_GLOBAL-1:0] global_net_en,
  input wire logic [NUM_REGIONAL-1:0] regional_net_en,
  input wire logic [NUM_EXT-1:0] ext_net_en,
  input wire logic [NUM_EXT-1:0] ext_user_signal,
  output logic [NUM_GLOBAL-1:0] global_clock_net,
  output logic [NUM_REGIONAL-1:0] regional_clock_net,
  output logic [NUM_EXT-1:0] ext_clock_pin,
  output logic [NUM_QUAD*ROW_PER_QUAD-1:0] row_clock,
  output logic [NUM_QUAD*CLUSTER_PICK-1:0] cluster_clock,
  output logic [NUM_QUAD*IO_PER_QUAD-1:0] io_clock
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Pin and PLL clocks are asynchronous to clk_sys; the networks here are
  // sampled images of them, so the fastest usable source is below 62.5 MHz.
  logic [NUM_PIN-1:0] pin_s1_q;
  logic [NUM_PIN-1:0] pin_s2_q;
  logic [NUM_PLL-1:0] c0_s1_q;
  logic [NUM_PLL-1:0] c0_s2_q;
  logic [NUM_PLL-1:0] c1_s1_q;
  logic [NUM_PLL-1:0] c1_s2_q;

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      c0_s1_q <= '0;
      c0_s2_q <= '0;
      c1_s1_q <= '0;
      c1_s2_q <= '0;
    end
    else
    begin
      pin_s1_q <= positive_clock_pin;
      pin_s2_q <= pin_s1_q;
      c0_s1_q <= pll_counter_output_zero;
      c0_s2_q <= c0_s1_q;
      c1_s1_q <= pll_counter_output_one;
      c1_s2_q <= c1_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic user_mode_q;
  logic [CELL_CFG_W-1:0] gcfg_q [NUM_GLOBAL];
  logic [CELL_CFG_W-1:0] rcfg_q [NUM_REGIONAL];
  logic [CELL_CFG_W-1:0] ecfg_q [NUM_EXT];
  logic [RES_SEL_W-1:0] row_sel_q [NUM_QUAD*ROW_PER_QUAD];
  logic [RES_SEL_W-1:0] io_sel_q [NUM_QUAD*IO_PER_QUAD];
  logic [CLUS_CFG_W-1:0] clus_cfg_q [NUM_QUAD];
  logic [DATA_W-1:0] rdata_q;

  logic aligned;
  logic cfg_wr;
  logic hit_ctrl;
  logic hit_global;
  logic hit_regional;
  logic hit_ext;
  logic hit_row;
  logic hit_io;
  logic hit_clus;
  logic [4:0] idx;
  logic [NUM_GLOBAL-1:0] g_en_state;
  logic [NUM_REGIONAL-1:0] r_en_state;
  logic [NUM_EXT-1:0] e_en_state;
  logic [DATA_W-1:0] rd_mux;

  assign aligned = (reg_addr[1:0] == 2'h0);
  assign idx = reg_addr[6:2];
  // Selection and power-down are configuration: frozen once in user mode
  assign cfg_wr = reg_wr && !user_mode_q;
  assign hit_ctrl = (reg_addr == ADDR_CTRL);
  assign hit_global = aligned && (reg_addr[9:6] == ADDR_GLOBAL_BASE[9:6]);
  assign hit_regional = aligned &&
                        (reg_addr[9:7] == ADDR_REGIONAL_BASE[9:7]);
  assign hit_ext = aligned && (reg_addr[9:4] == ADDR_EXT_BASE[9:4]);
  assign hit_row = aligned && (reg_addr[9:7] == ADDR_ROW_BASE[9:7]) &&
                   (idx < 5'(NUM_QUAD*ROW_PER_QUAD));
  assign hit_io = aligned && (reg_addr[9:7] == ADDR_IO_BASE[9:7]);
  assign hit_clus = aligned && (reg_addr[9:4] == ADDR_CLUSTER_BASE[9:4]);

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      user_mode_q <= 1'b0;
      for (int i = 0; i < NUM_GLOBAL; i++)
        gcfg_q[i] <= CELL_CFG_RESET;
      for (int i = 0; i < NUM_REGIONAL; i++)
        rcfg_q[i] <= CELL_CFG_RESET;
      for (int i = 0; i < NUM_EXT; i++)
        ecfg_q[i] <= CELL_CFG_RESET;
      for (int i = 0; i < NUM_QUAD*ROW_PER_QUAD; i++)
        row_sel_q[i] <= RES_SEL_RESET;
      for (int i = 0; i < NUM_QUAD*IO_PER_QUAD; i++)
        io_sel_q[i] <= RES_SEL_RESET;
      for (int i = 0; i < NUM_QUAD; i++)
        clus_cfg_q[i] <= CLUS_CFG_RESET;
    end
    else
    begin
      // Entry to user mode is one-way until reset
      if (reg_wr && hit_ctrl && reg_wdata[CTRL_USER_MODE_BIT])
        user_mode_q <= 1'b1;
      if (cfg_wr && hit_global)
        gcfg_q[idx[3:0]] <= reg_wdata[CELL_CFG_W-1:0];
      if (cfg_wr && hit_regional)
        rcfg_q[idx] <= reg_wdata[CELL_CFG_W-1:0];
      if (cfg_wr && hit_ext)
        ecfg_q[idx[1:0]] <= reg_wdata[CELL_CFG_W-1:0];
      if (cfg_wr && hit_row)
        row_sel_q[idx] <= reg_wdata[RES_SEL_W-1:0];
      if (cfg_wr && hit_io)
        io_sel_q[idx] <= reg_wdata[RES_SEL_W-1:0];
      if (cfg_wr && hit_clus)
        clus_cfg_q[idx[1:0]] <= reg_wdata[CLUS_CFG_W-1:0];
    end
  end

  always_comb
  begin
    rd_mux = '0;
    if (hit_ctrl)
      rd_mux = DATA_W'(user_mode_q);
    else if (reg_addr == ADDR_STAT_GLOBAL)
      rd_mux = DATA_W'(g_en_state);
    else if (reg_addr == ADDR_STAT_REGIONAL)
      rd_mux = r_en_state;
    else if (reg_addr == ADDR_STAT_EXT)
      rd_mux = DATA_W'(e_en_state);
    else if (hit_global)
      rd_mux = DATA_W'(gcfg_q[idx[3:0]]);
    else if (hit_regional)
      rd_mux = DATA_W'(rcfg_q[idx]);
    else if (hit_ext)
      rd_mux = DATA_W'(ecfg_q[idx[1:0]]);
    else if (hit_row)
      rd_mux = DATA_W'(row_sel_q[idx]);
    else if (hit_io)
      rd_mux = DATA_W'(io_sel_q[idx]);
    else if (hit_clus)
      rd_mux = DATA_W'(clus_cfg_q[idx[1:0]]);
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      rdata_q <= '0;
    else
      rdata_q <= reg_rd ? rd_mux : '0;
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // Global cells
  // ---------------------------------------------------------------
  // Switching here can leave runt pulses; downstream logic must filter.
  genvar g;
  generate
    for (g = 0; g < NUM_GLOBAL; g++)
    begin : gen_global
      logic [NUM_SRC-1:0] src;
      assign src = {global_internal_src[g],
                    c1_s2_q[g % NUM_PLL],
                    c0_s2_q[g % NUM_PLL],
                    pin_s2_q[2*(g % 8)+1],
                    pin_s2_q[2*(g % 8)]};
      clock_control_cell #(.DYNAMIC(1'b1)) u_cell (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .src(src),
        .static_sel(gcfg_q[g][CELL_SEL_LSB +: SEL_W]),
        .dyn_mode(gcfg_q[g][CELL_DYN_BIT]),
        .dyn_sel(global_dyn_sel[2*g +: 2]),
        .pll_dyn_ok(!CORNER_PLL_MASK[g % NUM_PLL]),
        .power_down(gcfg_q[g][CELL_PD_BIT]),
        .net_en(global_net_en[g]),
        .net_q(global_clock_net[g]),
        .en_q(g_en_state[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Regional cells and dual-regional drive
  // ---------------------------------------------------------------
  // Lines 0-3 of a quadrant come from top/bottom sources and pair with
  // the horizontal neighbour; lines 4-7 from left/right, vertical one.
  logic [NUM_REGIONAL-1:0] r_net;

  genvar r;
  generate
    for (r = 0; r < NUM_REGIONAL; r++)
    begin : gen_regional
      localparam int Q = r / REG_PER_QUAD;
      localparam int L = r % REG_PER_QUAD;
      localparam int PART = (L < 4) ? (r ^ 8) : (r ^ 16);
      logic [NUM_SRC-1:0] src;
      logic partner_dual;
      assign src = {regional_internal_src[r],
                    c1_s2_q[r % NUM_PLL],
                    c0_s2_q[r % NUM_PLL],
                    pin_s2_q[4*Q + 2*((L/2) % 2) + 1],
                    pin_s2_q[4*Q + 2*((L/2) % 2)]};
      clock_control_cell #(.DYNAMIC(1'b0)) u_cell (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .src(src),
        .static_sel(rcfg_q[r][CELL_SEL_LSB +: SEL_W]),
        .dyn_mode(1'b0),
        .dyn_sel(2'h0),
        .pll_dyn_ok(1'b0),
        .power_down(rcfg_q[r][CELL_PD_BIT]),
        .net_en(regional_net_en[r]),
        .net_q(r_net[r]),
        .en_q(r_en_state[r])
      );
      assign partner_dual = rcfg_q[PART][CELL_DUAL_BIT] &&
                            !rcfg_q[PART][CELL_CORNER_BIT];
      // Partner's cell drives this line too when it is set for dual use
      assign regional_clock_net[r] = partner_dual ? r_net[PART]
                                                  : r_net[r];
    end
  endgenerate

  // ---------------------------------------------------------------
  // External PLL output cells
  // ---------------------------------------------------------------
  logic [NUM_EXT-1:0] e_net;
  logic [NUM_EXT-1:0] ext_pin_q;

  genvar e;
  generate
    for (e = 0; e < NUM_EXT; e++)
    begin : gen_ext
      logic [NUM_SRC-1:0] src;
      assign src = {ext_internal_src[e], c1_s2_q[e], c0_s2_q[e],
                    pin_s2_q[2*e+1], pin_s2_q[2*e]};
      clock_control_cell #(.DYNAMIC(1'b0)) u_cell (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .src(src),
        .static_sel(ecfg_q[e][CELL_SEL_LSB +: SEL_W]),
        .dyn_mode(1'b0),
        .dyn_sel(2'h0),
        .pll_dyn_ok(1'b0),
        .power_down(ecfg_q[e][CELL_PD_BIT]),
        .net_en(ext_net_en[e]),
        .net_q(e_net[e]),
        .en_q(e_en_state[e])
      );
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      ext_pin_q <= '0;
    else
      for (int i = 0; i < NUM_EXT; i++)
        ext_pin_q[i] <= ecfg_q[i][CELL_IOSEL_BIT] ? e_net[i]
                                                  : ext_user_signal[i];
  end

  assign ext_clock_pin = ext_pin_q;

  // ---------------------------------------------------------------
  // Quadrant clock buses
  // ---------------------------------------------------------------
  logic [NUM_QUAD*ROW_PER_QUAD-1:0] row_q;
  logic [NUM_QUAD*CLUSTER_PICK-1:0] clus_q;
  logic [NUM_QUAD*IO_PER_QUAD-1:0] io_q;

  genvar q;
  generate
    for (q = 0; q < NUM_QUAD; q++)
    begin : gen_quad
      logic [QUAD_RES-1:0] res;
      logic [ROW_PER_QUAD-1:0] row_d;
      logic [CLUSTER_PICK-1:0] clus_d;
      logic [IO_PER_QUAD-1:0] io_d;
      assign res = {regional_clock_net[q*REG_PER_QUAD +: REG_PER_QUAD],
                    global_clock_net};
      always_comb
      begin
        for (int k = 0; k < ROW_PER_QUAD; k++)
          row_d[k] = (row_sel_q[q*ROW_PER_QUAD+k] < RES_SEL_W'(QUAD_RES)) ?
                     res[row_sel_q[q*ROW_PER_QUAD+k]] : 1'b0;
        for (int k = 0; k < IO_PER_QUAD; k++)
          io_d[k] = (io_sel_q[q*IO_PER_QUAD+k] < RES_SEL_W'(QUAD_RES)) ?
                    res[io_sel_q[q*IO_PER_QUAD+k]] : 1'b0;
        for (int k = 0; k < CLUSTER_PICK; k++)
          clus_d[k] = (clus_cfg_q[q][k*ROW_SEL_W +: ROW_SEL_W] <
                       ROW_SEL_W'(ROW_PER_QUAD)) ?
                      row_q[q*ROW_PER_QUAD +
                            clus_cfg_q[q][k*ROW_SEL_W +: ROW_SEL_W]] :
                      1'b0;
      end
      always_ff @(posedge clk_sys)
      begin
        if (sys_rst)
        begin
          row_q[q*ROW_PER_QUAD +: ROW_PER_QUAD] <= '0;
          io_q[q*IO_PER_QUAD +: IO_PER_QUAD] <= '0;
          clus_q[q*CLUSTER_PICK +: CLUSTER_PICK] <= '0;
        end
        else
        begin
          row_q[q*ROW_PER_QUAD +: ROW_PER_QUAD] <= row_d;
          io_q[q*IO_PER_QUAD +: IO_PER_QUAD] <= io_d;
          clus_q[q*CLUSTER_PICK +: CLUSTER_PICK] <= clus_d;
        end
      end
    end
  endgenerate

  assign row_clock = row_q;
  assign cluster_clock = clus_q;
  assign io_clock = io_q;

endmodule

`default_nettype wire

// file: testbench/user_logic_model.sv
// User logic model driving network enables and run-time selects
`timescale 1ns/1ps
`default_nettype none

module user_logic_model
  import clock_network_pkg::*;
(
  input wire logic clk_sys,
  input wire logic slow,
  input wire logic [51:0] req_en,
  input wire logic [31:0] req_sel,
  output var logic [51:0] en_q = 52'h0,
  output var logic [31:0] sel_q = 32'h0
);
  logic [51:0] hold_q = 52'h0;

  // ------
  // Slow mode adds a stage, as a pipelined controller would
  // ------
  always @(posedge clk_sys)
  begin
    hold_q <= req_en;
    en_q <= slow ? hold_q : req_en;
    sel_q <= req_sel;
  end
endmodule

`default_nettype wire

// file: testbench/clock_network_checker.sv
// Port checker for the clock network control block
`timescale 1ns/1ps
`default_nettype none

module clock_network_checker
  import clock_network_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [NUM_PIN-1:0] positive_clock_pin,
  input wire logic [NUM_PLL-1:0] pll_counter_output_zero,
  input wire logic [NUM_PLL-1:0] pll_counter_output_one,
  input wire logic [NUM_GLOBAL-1:0] global_internal_src,
  input wire logic [NUM_EXT-1:0] ext_internal_src,
  input wire logic [NUM_EXT-1:0] ext_user_signal,
  input wire logic [NUM_GLOBAL-1:0] global_net_en,
  input wire logic [NUM_GLOBAL-1:0] global_clock_net,
  input wire logic [NUM_REGIONAL-1:0] regional_clock_net,
  input wire logic [NUM_EXT-1:0] ext_clock_pin,
  input wire logic [NUM_QUAD*ROW_PER_QUAD-1:0] row_clock,
  input wire logic [NUM_QUAD*CLUSTER_PICK-1:0] cluster_clock,
  input wire logic [NUM_QUAD*IO_PER_QUAD-1:0] io_clock
);
  // ------
  // Idle sources of global 1 and external 0
  // ------
  wire logic g1_quiet = positive_clock_pin[3:2] == 2'h0
    && !pll_counter_output_zero[1] && !pll_counter_output_one[1]
    && !global_internal_src[1];
  wire logic x0_quiet = positive_clock_pin[1:0] == 2'h0
    && !pll_counter_output_zero[0] && !pll_counter_output_one[0]
    && !ext_internal_src[0] && !ext_user_signal[0];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // ------
  // Assertions
  // ------
  AST_RESET_QUIET: assert property ($fell(sys_rst) |->
    global_clock_net == 16'h0 && io_clock == 32'h0 && ext_clock_pin == 4'h0)
    else $error("outputs active after reset");
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data without read");
  AST_G1_QUIET: assert property (g1_quiet [*4] |=> !global_clock_net[1])
    else $error("global 1 active without source");
  // Window covers sync delay plus the low-phase capture
  AST_G1_EN_OFF: assert property (!global_net_en[1] [*4] |=>
    !$rose(global_clock_net[1]))
    else $error("global 1 rose while disabled");
  AST_ROW_Q0: assert property (global_clock_net == 16'h0 &&
    regional_clock_net[7:0] == 8'h00 |=> row_clock[5:0] == 6'h00)
    else $error("row clock without quadrant clock");
  AST_IO_Q0: assert property (global_clock_net == 16'h0 &&
    regional_clock_net[7:0] == 8'h00 |=> io_clock[7:0] == 8'h00)
    else $error("io clock without quadrant clock");
  AST_CLUSTER_Q0: assert property (row_clock[5:0] == 6'h00 |=>
    cluster_clock[2:0] == 3'h0)
    else $error("cluster clock without row clock");
  AST_EXT0_QUIET: assert property (x0_quiet [*6] |=> !ext_clock_pin[0])
    else $error("external pin 0 active without source");

  COV_G1_RISE: cover property ($rose(global_clock_net[1]));
  COV_EXT0: cover property (ext_clock_pin[0]);
  COV_ROW0: cover property (row_clock[0] && cluster_clock[0]);
endmodule

bind clock_network_select_gate clock_network_checker clock_network_checker_i (
  .clk_sys, .sys_rst, .reg_rd, .reg_rdata, .positive_clock_pin,
  .pll_counter_output_zero, .pll_counter_output_one, .global_internal_src,
  .ext_internal_src, .ext_user_signal, .global_net_en, .global_clock_net,
  .regional_clock_net, .ext_clock_pin, .row_clock, .cluster_clock, .io_clock
);

`default_nettype wire

// file: testbench/testbench.sv
// Self-checking testbench for the clock network control block
`timescale 1ns/1ps
`default_nettype none

module testbench
  import clock_network_pkg::*;
;
  typedef struct {
    int kind;
    logic [31:0] exp;
  } note_s;

  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic [ADDR_W-1:0] addr = 10'h0;
  logic [DATA_W-1:0] wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic slow = 1'h0;
  logic probe = 1'h0;
  logic rd_q = 1'h0;
  logic [15:0] pin = 16'h0;
  logic [11:0] pc0 = 12'h0;
  logic [11:0] pc1 = 12'h0;
  logic [15:0] gint = 16'h0;
  logic [31:0] rint = 32'h0;
  logic [3:0] xint = 4'h0;
  logic [3:0] xuser = 4'h0;
  logic [51:0] req_en = 52'h0;
  logic [31:0] req_sel = 32'h0;
  logic [51:0] en;
  logic [31:0] dsel;
  logic [31:0] rdata;
  logic [15:0] gnet;
  logic [31:0] rnet;
  logic [3:0] xpin;
  logic [23:0] row;
  logic [11:0] clus;
  logic [31:0] ioc;
  note_s notes[$];
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  string what [7] = '{"rdata", "global", "regional", "ext", "row",
    "cluster", "io"};

  always #4 clk_sys = ~clk_sys;

  user_logic_model user_logic_model_i (
    .clk_sys, .slow, .req_en, .req_sel, .en_q(en), .sel_q(dsel)
  );

  clock_network_select_gate clock_network_select_gate_i (
    .clk_sys, .sys_rst, .reg_addr(addr), .reg_wdata(wdata), .reg_wr,
    .reg_rd, .reg_rdata(rdata), .positive_clock_pin(pin),
    .pll_counter_output_zero(pc0), .pll_counter_output_one(pc1),
    .global_internal_src(gint), .regional_internal_src(rint),
    .ext_internal_src(xint), .global_dyn_sel(dsel),
    .global_net_en(en[15:0]), .regional_net_en(en[47:16]),
    .ext_net_en(en[51:48]), .ext_user_signal(xuser),
    .global_clock_net(gnet), .regional_clock_net(rnet),
    .ext_clock_pin(xpin), .row_clock(row), .cluster_clock(clus),
    .io_clock(ioc)
  );

  // ------
  // Scoreboard
  // ------
  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic compare(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [31:0] pick(int k);
    case (k)
      0: return rdata;
      1: return 32'(gnet);
      2: return rnet;
      3: return 32'(xpin);
      4: return 32'(row);
      5: return 32'(clus);
      default: return ioc;
    endcase
  endfunction

  // Read notes are popped before probe notes of the same cycle
  always @(posedge clk_sys)
  begin
    note_s n;
    rd_q <= reg_rd;
    for (int j = 0; j < 2; j++)
      if ((j == 0 ? rd_q : probe) && notes.size() > 0)
      begin
        n = notes.pop_front();
        compare(what[n.kind], pick(n.kind), n.exp);
      end
  end

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      miscompares++;
      final_report();
    end
  end

  // ------
  // Drivers
  // ------
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic wr(logic [9:0] a, logic [31:0] d);
    reg_wr <= 1'h1;
    addr <= a;
    wdata <= d;
    tick(1);
    reg_wr <= 1'h0;
    tick(1);
  endtask

  task automatic rd(logic [9:0] a, logic [31:0] e);
    reg_rd <= 1'h1;
    addr <= a;
    notes.push_back('{0, e});
    tick(1);
    reg_rd <= 1'h0;
    tick(1);
  endtask

  task automatic look(int k, logic [31:0] e);
    probe <= 1'h1;
    notes.push_back('{k, e});
    tick(1);
    probe <= 1'h0;
    tick(1);
  endtask

  task automatic set_src(int g, int s, logic v);
    case (s)
      0: pin[2*(g%8)] <= v;
      1: pin[2*(g%8)+1] <= v;
      2: pc0[g%12] <= v;
      3: pc1[g%12] <= v;
      default: gint[g] <= v;
    endcase
  endtask

  // Other sources high first, so a wrong selection shows up
  task automatic follow(int g, int s, logic [31:0] on);
    for (int k = 0; k < 5; k++)
      set_src(g, k, k != s);
    tick(6);
    look(1, 32'h0);
    set_src(g, s, 1'h1);
    tick(6);
    look(1, on);
    for (int k = 0; k < 5; k++)
      set_src(g, k, 1'h0);
    tick(6);
  endtask

  // ------
  // Main sequence
  // ------
  initial
  begin
    void'($urandom(31509));
    tick(12);
    sys_rst <= 1'h0;
    tick(2);
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_GLOBAL_BASE, 32'h10);
    rd(ADDR_REGIONAL_BASE + 10'h07C, 32'h10);
    rd(ADDR_EXT_BASE, 32'h10);
    rd(ADDR_CLUSTER_BASE, 32'h88);
    rd(10'h3F0, 32'h0);
    rd(10'h042, 32'h0);
    req_en[1] <= 1'h1;
    follow(1, 0, 32'h0);
    for (int s = 0; s < 5; s++)
    begin
      wr(ADDR_GLOBAL_BASE + 10'h004, 32'(s));
      follow(1, s, 32'h2);
    end
    slow <= 1'h1;
    wr(ADDR_GLOBAL_BASE + 10'h004, 32'h0C);
    for (int s = 0; s < 4; s++)
    begin
      req_sel[3:2] <= 2'(s);
      follow(1, s, 32'h2);
    end
    req_en[7] <= 1'h1;
    req_sel[15:14] <= 2'h2;
    wr(ADDR_GLOBAL_BASE + 10'h01C, 32'h08);
    follow(7, 0, 32'h80);
    set_src(1, 3, 1'h1);
    tick(6);
    req_en[1] <= 1'h0;
    tick(6);
    look(1, 32'h2);
    set_src(1, 3, 1'h0);
    tick(6);
    set_src(1, 3, 1'h1);
    tick(6);
    look(1, 32'h0);
    set_src(1, 3, 1'h0);
    req_en[1] <= 1'h1;
    wr(ADDR_ROW_BASE, 32'h1);
    wr(ADDR_IO_BASE, 32'h1);
    set_src(1, 3, 1'h1);
    tick(6);
    look(4, 32'h1);
    look(5, 32'h1);
    look(6, 32'h1);
    set_src(1, 3, 1'h0);
    req_en[48] <= 1'h1;
    wr(ADDR_EXT_BASE, 32'h24);
    // Enable must be taken while the chosen source is still low
    tick(2);
    xint[0] <= 1'h1;
    tick(6);
    look(3, 32'h1);
    wr(ADDR_EXT_BASE, 32'h04);
    tick(6);
    look(3, 32'h0);
    xuser[0] <= 1'h1;
    tick(6);
    look(3, 32'h1);
    req_en[16] <= 1'h1;
    wr(ADDR_REGIONAL_BASE, 32'h04);
    tick(2);
    for (int i = 0; i < 24; i++)
    begin
      rint <= $urandom;
      probe <= i > 0;
      if (i > 0)
        notes.push_back('{2, {31'h0, rint[0]}});
      tick(1);
    end
    probe <= 1'h0;
    rint <= 32'h0;
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_REGIONAL_BASE, 32'h10);
    rd(ADDR_REGIONAL_BASE, 32'h04);
    rd(ADDR_CTRL, 32'h1);
    req_sel[3:2] <= 2'h0;
    follow(1, 0, 32'h2);
    final_report();
  end
endmodule

`default_nettype wire
